// ==== scsc_clock_ctrl.sv ====
// system clock generator with protected standby control and oscillator control
// ==========================================================================
`timescale 1ns/100ps
`default_nettype none
module scsc_clock_ctrl
  import scsc_pkg::*;
#(
  parameter int SETTLE_BASE_LOG2 = SCSC_SETTLE_BASE_LOG2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire scsc_sfr_req_t sfrReq,
  input wire logic nmiEdge,
  input wire logic oscInputPin,
  input wire logic oscReturnPin,
  output logic [7:0] sfrRdata,
  output logic opErrIrq,
  output logic [SCSC_RET_ADDR_W-1:0] opErrRetAddr,
  output logic oscAmpEnable,
  output logic sysClk,
  output logic haltMode,
  output logic idleMode,
  output logic stopMode,
  output logic settleBusy
);

  // ==========================================================================
  // state
  typedef struct packed {
    scsc_mode_t mode;
    logic external_clock_select;
    logic [SCSC_CODE_W-1:0] settleCode;
    logic [7:0] rdata;
    logic opErr;
    logic [SCSC_RET_ADDR_W-1:0] errAddr;
    logic ampEn;
    logic settling;
    logic settleStart;
    logic clkHold;
    logic haltOut;
    logic idleOut;
    logic stopOut;
  } scsc_state_t;

  localparam scsc_state_t STATE_RESET = '{
    mode: scsc_mode_t'(SCSC_STANDBY_RESET[1:0]),
    external_clock_select: SCSC_OSC_RESET[SCSC_EXTERNAL_CLOCK_SELECT_BIT],
    settleCode: SCSC_OSC_RESET[SCSC_CODE_W-1:0],
    rdata: 8'h00,
    opErr: 1'b0,
    errAddr: '0,
    ampEn: 1'b1,
    settling: 1'b0,
    settleStart: 1'b0,
    clkHold: 1'b0,
    haltOut: SCSC_STANDBY_RESET[1:0] == SCSC_MODE_HALT,
    idleOut: SCSC_STANDBY_RESET[1:0] == SCSC_MODE_IDLE,
    stopOut: SCSC_STANDBY_RESET[1:0] == SCSC_MODE_STOP
  };

  scsc_state_t s;
  scsc_state_t next_s;
  logic timerBusy;
  logic timerDone;

  // ==========================================================================
  // access decode
  logic hitStandby;
  logic hitOsc;
  logic protMove;
  logic complementOk;
  logic [7:0] standbyView;
  logic [7:0] oscView;
  logic oscByteAcc;

  assign hitStandby = sfrReq.addr == SCSC_ADDR_STANDBY;
  assign hitOsc = sfrReq.addr == SCSC_ADDR_OSC;
  assign protMove = sfrReq.wr && hitStandby && sfrReq.kind == SCSC_ACC_PROT_MOVE;
  assign complementOk = sfrReq.opByte3 == ~sfrReq.opByte4;
  assign standbyView = {SCSC_STANDBY_FIXED, s.mode};
  assign oscView = {s.external_clock_select, 4'h0, s.settleCode};
  assign oscByteAcc = hitOsc && sfrReq.kind == SCSC_ACC_BYTE;

  // stop decode is shared by the hold, amplifier, wake and output paths
  function automatic logic isStop(input scsc_mode_t m);
    return m == SCSC_MODE_STOP;
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.opErr = 1'b0;
    next_s.settleStart = 1'b0;

    if (protMove) begin
      if (complementOk) begin
        next_s.mode = scsc_mode_t'(sfrReq.wdata[1:0]);
      end else begin
        // error return points back at the faulting move itself
        next_s.opErr = 1'b1;
        next_s.errAddr = sfrReq.instrAddr;
      end
    end
    // other write kinds to the standby register fall through untouched

    if (sfrReq.wr && oscByteAcc) begin
      next_s.external_clock_select = sfrReq.wdata[SCSC_EXTERNAL_CLOCK_SELECT_BIT];
      next_s.settleCode = sfrReq.wdata[SCSC_CODE_LSB +: SCSC_CODE_W];
    end

    // nmi release overrides a same-cycle standby write, the wake must not be lost
    if (isStop(s.mode) && nmiEdge) begin
      next_s.mode = SCSC_MODE_NORMAL;
      next_s.settling = 1'b1;
      next_s.settleStart = 1'b1;
    end else if (timerDone) begin
      next_s.settling = 1'b0;
    end

    if (sfrReq.rd) begin
      if (hitStandby) begin
        next_s.rdata = standbyView;
      end else if (oscByteAcc) begin
        next_s.rdata = oscView;
      end else begin
        next_s.rdata = 8'h00;
      end
    end

    // amplifier off in STOP, and off when the return pin carries the clock
    next_s.ampEn = !isStop(next_s.mode) && !next_s.external_clock_select;
    next_s.clkHold = isStop(next_s.mode) || next_s.settling;
    // decoded mode lines leave from flops, in step with the mode bits
    next_s.haltOut = next_s.mode == SCSC_MODE_HALT;
    next_s.idleOut = next_s.mode == SCSC_MODE_IDLE;
    next_s.stopOut = isStop(next_s.mode);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // sub blocks
  scsc_osc_divider u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .oscInputPin(oscInputPin),
    .oscReturnPin(oscReturnPin),
    .useReturnPin(s.external_clock_select),
    .clkHold(s.clkHold),
    .sysClk(sysClk)
  );

  scsc_settle_timer #(
    .BASE_LOG2(SETTLE_BASE_LOG2)
  ) u_settle (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(s.settleStart),
    .code(s.settleCode),
    .busy(timerBusy),
    .done(timerDone)
  );

  // ==========================================================================
  // outputs
  assign sfrRdata = s.rdata;
  assign opErrIrq = s.opErr;
  assign opErrRetAddr = s.errAddr;
  assign oscAmpEnable = s.ampEn;
  assign haltMode = s.haltOut;
  assign idleMode = s.idleOut;
  assign stopMode = s.stopOut;
  assign settleBusy = s.settling;

  // ==========================================================================
  // checks
  sequence badProtMove;
    protMove && !complementOk;
  endsequence

  sequence goodProtMove;
    protMove && complementOk && !(s.mode == SCSC_MODE_STOP && nmiEdge);
  endsequence

  sequence stopReleased;
    s.mode == SCSC_MODE_STOP && nmiEdge;
  endsequence

  sequence oscByteRead;
    sfrReq.rd && oscByteAcc;
  endsequence

  a_stop_osc_off: assert property (@(posedge clk_sys) disable iff (rst)
    stopMode |-> !oscAmpEnable)
    else $error("oscillator running in stop mode");

  a_external_clock_select_osc_off: assert property (@(posedge clk_sys) disable iff (rst)
    s.external_clock_select |-> !oscAmpEnable)
    else $error("oscillator running with external clock select set");

  a_bad_move_err: assert property (@(posedge clk_sys) disable iff (rst)
    badProtMove ##0 (!nmiEdge || s.mode != SCSC_MODE_STOP)
    |=> opErrIrq && $stable(s.mode) && opErrRetAddr == $past(sfrReq.instrAddr))
    else $error("malformed protected move not flagged");

  a_good_move_upd: assert property (@(posedge clk_sys) disable iff (rst)
    goodProtMove |=> !opErrIrq && s.mode == $past(sfrReq.wdata[1:0]))
    else $error("protected move did not update the mode");

  a_other_wr_ign: assert property (@(posedge clk_sys) disable iff (rst)
    sfrReq.wr && hitStandby && sfrReq.kind != SCSC_ACC_PROT_MOVE && !nmiEdge
    |=> $stable(s.mode) && !opErrIrq)
    else $error("plain write changed standby register");

  a_std_read_back: assert property (@(posedge clk_sys) disable iff (rst)
    sfrReq.rd && hitStandby |=> sfrRdata == {SCSC_STANDBY_FIXED, $past(s.mode)})
    else $error("standby read back wrong");

  a_osc_byte_only: assert property (@(posedge clk_sys) disable iff (rst)
    sfrReq.wr && hitOsc && sfrReq.kind != SCSC_ACC_BYTE
    |=> $stable(s.external_clock_select) && $stable(s.settleCode))
    else $error("non-byte write reached oscillator control");

  a_reset_values: assert property (@(posedge clk_sys)
    rst |=> s.mode == SCSC_MODE_NORMAL && !s.external_clock_select && s.settleCode == 3'h0 && oscAmpEnable)
    else $error("reset values wrong");

  a_nmi_settles: assert property (@(posedge clk_sys) disable iff (rst)
    stopReleased |=> settleBusy && !stopMode ##1 timerBusy)
    else $error("stop release did not start the settle wait");

  a_hold_in_settle: assert property (@(posedge clk_sys) disable iff (rst)
    settleBusy |-> s.clkHold ##1 (settleBusy || $past(timerDone)))
    else $error("clock released during settle wait");

  a_err_cause: assert property (@(posedge clk_sys) disable iff (rst)
    opErrIrq |-> $past(protMove && !complementOk))
    else $error("operand error without a malformed move");

  a_err_addr_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !(protMove && !complementOk) |=> $stable(opErrRetAddr))
    else $error("saved return address changed without an error");

  a_rdata_holds: assert property (@(posedge clk_sys) disable iff (rst)
    !sfrReq.rd |=> $stable(sfrRdata))
    else $error("read data changed without a read");

  a_nmi_no_stop: assert property (@(posedge clk_sys) disable iff (rst)
    nmiEdge && !stopMode && !settleBusy |=> !settleBusy)
    else $error("nmi outside stop started a settle wait");

  a_settle_from_stop: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(settleBusy) |-> $past(stopMode) && $past(nmiEdge))
    else $error("settle wait began without a stop release");

  a_amp_runs: assert property (@(posedge clk_sys) disable iff (rst)
    !stopMode && !s.external_clock_select |-> oscAmpEnable)
    else $error("oscillator held off outside stop");

  a_osc_read_back: assert property (@(posedge clk_sys) disable iff (rst)
    oscByteRead |=> sfrRdata == {$past(s.external_clock_select), 4'h0, $past(s.settleCode)})
    else $error("oscillator control read back wrong");

  a_other_rd_zero: assert property (@(posedge clk_sys) disable iff (rst)
    sfrReq.rd && !hitStandby && !oscByteAcc |=> sfrRdata == 8'h00)
    else $error("non-byte or unmapped read returned data");

  a_stop_clk_held: assert property (@(posedge clk_sys) disable iff (rst)
    stopMode |=> $stable(sysClk))
    else $error("system clock moved in stop mode");

endmodule
`default_nettype wire

// ==== scsc_osc_divider.sv ====
// oscillator pin synchroniser, source select and divide-by-two stage
`timescale 1ns/100ps
`default_nettype none
module scsc_osc_divider
  import scsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic oscInputPin,
  input wire logic oscReturnPin,
  input wire logic useReturnPin,
  input wire logic clkHold,
  output logic sysClk
);

  logic [SCSC_SYNC_STAGES-1:0] syncIn;
  logic [SCSC_SYNC_STAGES-1:0] syncRet;
  logic prevSel;
  logic selNow;
  logic riseSel;

  // second stage only feeds the select and edge logic
  assign selNow = useReturnPin ? syncRet[SCSC_SYNC_STAGES-1] : syncIn[SCSC_SYNC_STAGES-1];
  assign riseSel = selNow && !prevSel;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncIn <= '0;
      syncRet <= '0;
      prevSel <= 1'b0;
      sysClk <= 1'b0;
    end else begin
      syncIn <= {syncIn[SCSC_SYNC_STAGES-2:0], oscInputPin};
      syncRet <= {syncRet[SCSC_SYNC_STAGES-2:0], oscReturnPin};
      prevSel <= selNow;
      if (riseSel && !clkHold) begin
        sysClk <= !sysClk;
      end
    end
  end

  a_div_by_two: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(sysClk) |-> $past(riseSel) && !$past(clkHold))
    else $error("system clock toggled without a source edge");

endmodule
`default_nettype wire

// ==== scsc_osc_source.sv ====
// behavioural resonator or external clock source at the oscillator pins
`timescale 1ns/100ps
`default_nettype none
module scsc_osc_source #(
  parameter int HALF = 4
) (
  input wire logic clk_sys,
  input wire logic ampOn,
  input wire logic extClock,
  input wire logic returnDriven,
  output var logic oscInputPin,
  output logic oscReturnPin
);
  int cnt = 0;
  logic noise = 1'b0;
  initial oscInputPin = 1'b0;
  // ==========================================
  // source waveform
  // a resonator only swings while the amplifier runs; an external source always does
  always @(posedge clk_sys) begin
    noise <= ~noise;
    if (ampOn || extClock) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        oscInputPin <= ~oscInputPin;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
  // open pin floats, so show a changing pattern rather than a held level
  assign oscReturnPin = returnDriven ? ~oscInputPin : noise;
endmodule
`default_nettype wire

// ==== scsc_pkg.sv ====
// shared constants and types of the system clock and standby control block
`default_nettype none
package scsc_pkg;

  // ==========================================================================
  // register map
  localparam logic [15:0] SCSC_ADDR_STANDBY = 16'hffc0;
  localparam logic [15:0] SCSC_ADDR_OSC = 16'hffcf;
  localparam logic [7:0] SCSC_STANDBY_RESET = 8'h30;
  localparam logic [5:0] SCSC_STANDBY_FIXED = 6'h0c;
  localparam logic [7:0] SCSC_OSC_RESET = 8'h00;
  localparam int SCSC_HALT_BIT = 0;
  localparam int SCSC_STOP_BIT = 1;
  localparam int SCSC_EXTERNAL_CLOCK_SELECT_BIT = 7;
  localparam int SCSC_CODE_LSB = 0;
  localparam int SCSC_CODE_W = 3;

  // ==========================================================================
  // timing
  localparam int SCSC_SYNC_STAGES = 2;
  localparam int SCSC_SETTLE_BASE_LOG2 = 12;
  localparam int SCSC_SETTLE_CNT_W = 20;
  localparam int SCSC_RET_ADDR_W = 20;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    SCSC_MODE_NORMAL = 2'b00,
    SCSC_MODE_HALT = 2'b01,
    SCSC_MODE_STOP = 2'b10,
    SCSC_MODE_IDLE = 2'b11
  } scsc_mode_t;

  typedef enum logic [1:0] {
    SCSC_ACC_BYTE = 2'b00,
    SCSC_ACC_BIT = 2'b01,
    SCSC_ACC_WORD = 2'b10,
    SCSC_ACC_PROT_MOVE = 2'b11
  } scsc_acc_t;

  typedef struct packed {
    logic wr;
    logic rd;
    scsc_acc_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] opByte3;
    logic [7:0] opByte4;
    logic [SCSC_RET_ADDR_W-1:0] instrAddr;
  } scsc_sfr_req_t;

  // length of the stabilisation wait in system clocks for a given code
  function automatic logic [SCSC_SETTLE_CNT_W-1:0] scsc_settle_len(
    input int baseLog2,
    input logic [SCSC_CODE_W-1:0] code
  );
    logic [SCSC_SETTLE_CNT_W-1:0] one;
    one = {{(SCSC_SETTLE_CNT_W-1){1'b0}}, 1'b1};
    return one << (baseLog2 + int'(code));
  endfunction

endpackage
`default_nettype wire

// ==== scsc_settle_timer.sv ====
// oscillation stabilisation wait timer
`timescale 1ns/100ps
`default_nettype none
module scsc_settle_timer
  import scsc_pkg::*;
#(
  parameter int BASE_LOG2 = SCSC_SETTLE_BASE_LOG2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [SCSC_CODE_W-1:0] code,
  output logic busy,
  output logic done
);

  logic [SCSC_SETTLE_CNT_W-1:0] remain;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      remain <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remain <= scsc_settle_len(BASE_LOG2, code) - 1'b1;
        busy <= 1'b1;
      end else if (busy) begin
        if (remain == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - 1'b1;
        end
      end
    end
  end

  a_timer_ends: assert property (@(posedge clk_sys) disable iff (rst)
    done |-> $past(busy) && !busy)
    else $error("settle done without a running wait");

endmodule
`default_nettype wire

// ==== system_clock_and_standby_ctrl_tb.sv ====
// self-checking testbench of the clock and standby control block
`timescale 1ns/100ps
`default_nettype none
module system_clock_and_standby_ctrl_tb import scsc_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  scsc_sfr_req_t req = '0;
  logic nmiEdge = 1'b0;
  logic extSrc = 1'b0;
  logic driveRet = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic [19:0] retAddr;
  logic ampOn, sysClk, haltMode, idleMode, stopMode, settleBusy, x1, x2;
  logic sysPrev = 1'b0;
  int failures = 0;
  int nChecks = 0;
  int cyc = 0;
  int lastRise = 0;
  int lastGap = 0;
  int rises = 0;
  int n;

  always #12.5 clk_sys = ~clk_sys;

  scsc_clock_ctrl #(.SETTLE_BASE_LOG2(2)) i_dut (.clk_sys(clk_sys), .rst(rst), .sfrReq(req),
    .nmiEdge(nmiEdge), .oscInputPin(x1), .oscReturnPin(x2), .sfrRdata(rdata), .opErrIrq(irq),
    .opErrRetAddr(retAddr), .oscAmpEnable(ampOn), .sysClk(sysClk), .haltMode(haltMode),
    .idleMode(idleMode), .stopMode(stopMode), .settleBusy(settleBusy));

  scsc_osc_source #(.HALF(4)) i_src (.clk_sys(clk_sys), .ampOn(ampOn), .extClock(extSrc),
    .returnDriven(driveRet), .oscInputPin(x1), .oscReturnPin(x2));

  // ==========================================
  // system clock edge monitor
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    sysPrev <= sysClk;
    if (sysClk === 1'b1 && sysPrev === 1'b0) begin
      lastGap <= cyc - lastRise;
      lastRise <= cyc;
      rises <= rises + 1;
    end
  end

  // ==========================================
  // access and compare tasks
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic access(input logic w, input scsc_acc_t k, input logic [15:0] a,
    input logic [7:0] d, input logic [7:0] b4);
    @(posedge clk_sys);
    req <= '{wr: w, rd: !w, kind: k, addr: a, wdata: d, opByte3: d, opByte4: b4,
      instrAddr: {12'h123, d}};
    @(posedge clk_sys);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1;
  endtask

  task automatic rdchk(input string what, input logic [15:0] a, input logic [7:0] exp);
    access(1'b0, SCSC_ACC_BYTE, a, 8'h00, 8'h00);
    check(what, {12'h000, rdata}, {12'h000, exp});
  endtask

  task automatic wmove(input logic [7:0] d);
    access(1'b1, SCSC_ACC_PROT_MOVE, SCSC_ADDR_STANDBY, d, ~d);
  endtask

  task automatic pulse_nmi;
    @(posedge clk_sys);
    nmiEdge <= 1'b1;
    @(posedge clk_sys);
    nmiEdge <= 1'b0;
    #1;
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================
  // tests
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    rdchk("standby reset", SCSC_ADDR_STANDBY, 8'h30);
    rdchk("osc reset", SCSC_ADDR_OSC, 8'h00);
    check("amp after reset", 20'(ampOn), 20'h1);
    repeat (60) @(posedge clk_sys);
    #1;
    check("sysclk period", 20'(lastGap), 20'h10);
    $display("test reset_and_divide done");
    for (int m = 3; m >= 0; m--) begin
      if (m != 2) begin
        wmove({6'h15, 2'(m)});
        rdchk("standby mode", SCSC_ADDR_STANDBY, {6'h0c, 2'(m)});
        check("mode outputs", {17'h0, stopMode, haltMode, idleMode},
          {17'h0, m == 2, m == 1, m == 3});
      end
    end
    $display("test protected_move done");
    for (int k = 0; k < 3; k++) begin
      access(1'b1, scsc_acc_t'(k), SCSC_ADDR_STANDBY, 8'h01, 8'hfe);
      check("irq on plain write", 20'(irq), 20'h0);
      rdchk("standby after plain write", SCSC_ADDR_STANDBY, 8'h30);
    end
    $display("test plain_write done");
    access(1'b1, SCSC_ACC_PROT_MOVE, SCSC_ADDR_STANDBY, 8'h01, 8'h00);
    check("irq on bad move", 20'(irq), 20'h1);
    check("return address", retAddr, 20'h12301);
    @(posedge clk_sys);
    #1;
    check("irq single cycle", 20'(irq), 20'h0);
    rdchk("standby after bad move", SCSC_ADDR_STANDBY, 8'h30);
    $display("test bad_move done");
    access(1'b1, SCSC_ACC_BYTE, SCSC_ADDR_OSC, 8'hff, 8'h00);
    rdchk("osc byte write", SCSC_ADDR_OSC, 8'h87);
    access(1'b0, SCSC_ACC_WORD, SCSC_ADDR_OSC, 8'h00, 8'h00);
    check("osc word read", 20'(rdata), 20'h0);
    check("amp off with select", 20'(ampOn), 20'h0);
    access(1'b1, SCSC_ACC_BIT, SCSC_ADDR_OSC, 8'h00, 8'h00);
    rdchk("osc bit write", SCSC_ADDR_OSC, 8'h87);
    @(posedge clk_sys);
    extSrc <= 1'b1;
    driveRet <= 1'b1;
    repeat (80) @(posedge clk_sys);
    #1;
    check("return pin period", 20'(lastGap), 20'h10);
    access(1'b1, SCSC_ACC_BYTE, SCSC_ADDR_OSC, 8'h03, 8'h00);
    extSrc <= 1'b0;
    driveRet <= 1'b0;
    rdchk("osc code", SCSC_ADDR_OSC, 8'h03);
    check("amp back on", 20'(ampOn), 20'h1);
    $display("test osc_register done");
    pulse_nmi();
    check("nmi outside stop", {18'h0, settleBusy, stopMode}, 20'h0);
    wmove(8'h02);
    check("stop amp", {18'h0, stopMode, ampOn}, 20'h2);
    n = rises;
    repeat (40) @(posedge clk_sys);
    #1;
    check("clock frozen", 20'(rises - n), 20'h0);
    pulse_nmi();
    check("release", {17'h0, stopMode, settleBusy, ampOn}, 20'h3);
    repeat (20) @(posedge clk_sys);
    #1;
    check("still settling", 20'(settleBusy), 20'h1);
    n = 0;
    while (settleBusy !== 1'b0 && n < 30) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    // wait of 2^(2+3) cycles plus two of latency, less the 20 already waited
    check("settle end", 20'(n), 20'((1 << (2 + 3)) + 2 - 20));
    repeat (60) @(posedge clk_sys);
    #1;
    check("clock resumed", 20'(lastGap), 20'h10);
    rdchk("mode after release", SCSC_ADDR_STANDBY, 8'h30);
    $display("test stop_release done");
    wmove(8'h01);
    access(1'b1, SCSC_ACC_BYTE, SCSC_ADDR_OSC, 8'h85, 8'h00);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("state after second reset", {17'h0, haltMode, ampOn, settleBusy}, 20'h2);
    rdchk("standby second reset", SCSC_ADDR_STANDBY, 8'h30);
    rdchk("osc second reset", SCSC_ADDR_OSC, 8'h00);
    $display("test mid_reset done");
    finish_test;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    $display("watchdog expired");
    finish_test;
  end
endmodule
`default_nettype wire
